// ---- isl_defs.vh ----
// Register offsets, field positions and reset values of the transfer status block.
// Assumes an 8-bit byte address on the register port, one 32-bit word per register.
`ifndef ISL_DEFS_VH
`define ISL_DEFS_VH

// Register byte offsets.
`define ISL_OFF_CTRL      8'h00
`define ISL_OFF_STAT      8'h04
`define ISL_OFF_LEN       8'h08
`define ISL_OFF_DATA      8'h10
`define ISL_OFF_STRETCH   8'h1c

// Control register fields.
`define ISL_C_READ        0
`define ISL_C_CLEAR_LO    4
`define ISL_C_CLEAR_HI    5
`define ISL_C_BEGIN       7
`define ISL_C_DONE_EN     8
`define ISL_C_REFILL_EN   9
`define ISL_C_DRAIN_EN    10

// Status register fields.
`define ISL_S_ACTIVE      0
`define ISL_S_DONE        1
`define ISL_S_REFILL      2
`define ISL_S_DRAIN       3
`define ISL_S_SPACE       4
`define ISL_S_DATA        5
`define ISL_S_EMPTY       6
`define ISL_S_FULL        7
`define ISL_S_NOACK       8
`define ISL_S_STRETCH     9

// Reset values.
`define ISL_RST_LEN       16'h0000
`define ISL_RST_STRETCH   16'h0040

// Buffer depth in bytes.
`define ISL_DEPTH         16
`endif

// ---- isl_status.v ----
// Status flags, byte count and shared byte buffer of a single-master two-wire controller.
// Assumes a bit engine on the same clock that sends, receives and ends bytes, and a
// register port on the same clock; the serial clock line arrives from the pins.
//
// Function
// RL1: Status bit 0 reads 1 during a transfer, 0 when idle.
// RL2: Status bit 1 sets when a transfer finishes; write 1 clears it.
// RL3: Interrupt asserts while done flag and done enable are both set.
// RL4: Bit 2 flags refill need during write while buffer under a quarter full; code also needs fewer bytes buffered than remain to send.
// RL5: Interrupt asserts while refill flag and refill enable are both set.
// RL6: Empty buffer mid-write pauses sending until more data is written.
// RL7: Bit 3 flags drain need during read while buffer three quarters full.
// RL8: Interrupt asserts while drain flag and drain enable are both set.
// RL9: Bit 7 shows buffer full; read transfer then stops clocking until space.
// RL10: Bit 4 shows buffer has room for a byte; resets to one.
// RL11: Data writes to a full buffer are dropped without change.
// RL12: Bit 5 shows buffer holds at least one byte.
// RL13: Software checks bit 5 before reading data; empty reads are invalid.
// RL14: Bit 6 shows buffer empty, resets to one; write sends nothing then.
// RL15: Bit 8 sets on a missing acknowledge; write 1 clears it.
// RL16: Bit 9 sets on a clock stretch timeout; write 1 clears it.
// RL17: Length register holds a 16-bit byte count, reset zero.
// RL18: During a transfer length reads the remaining count, counting down per byte.
// RL19: After completion with done set, length reads zero.
// RL20: Idle and not done, length reads last written value, kept for reuse.
// RL21: One shared sixteen-byte buffer; thresholds taken against that depth.
// RL22: Writing 1 to begin bit starts a transfer; it reads back 0.
// RL23: Stretch limit of zero disables the timeout check.
// RL24: Direction bit 0 selects write transfer, 1 selects read transfer.
// RL25: Refill and drain flags stay low without an active matching transfer.
`include "isl_defs.vh"

module isl_status #(
    parameter DEPTH = `ISL_DEPTH,
    parameter AW    = 4
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [31:0] reg_wdata,
    output wire [31:0] reg_rdata,
    output wire        irq,
    input  wire        scl_in,
    input  wire        scl_release,
    input  wire        scl_tick,
    output wire        eng_start,
    output wire        eng_read,
    output wire [7:0]  eng_tx_data,
    output wire        eng_tx_valid,
    input  wire        eng_tx_take,
    input  wire [7:0]  eng_rx_data,
    input  wire        eng_rx_push,
    output wire        eng_rx_room,
    input  wire        eng_ack_fail,
    input  wire        eng_finish
);

    // Thresholds are worked out at full width, then cut to the count width on purpose.
    localparam integer FULL_I   = DEPTH;
    localparam integer QTR_I    = DEPTH / 4;
    localparam integer TQTR_I   = (DEPTH * 3) / 4;
    localparam [AW:0] CNT_FULL  = FULL_I[AW:0];
    localparam [AW:0] CNT_QTR   = QTR_I[AW:0];
    localparam [AW:0] CNT_3QTR  = TQTR_I[AW:0];
    localparam [AW:0] CNT_ONE   = {{AW{1'b0}}, 1'b1};

    // Register and buffer state.
    reg [7:0]    mem_ff [0:DEPTH-1];
    reg [AW-1:0] wptr_ff;
    reg [AW-1:0] rptr_ff;
    reg [AW:0]   cnt_ff;
    reg          active_ff;
    reg          done_ff;
    reg          noack_ff;
    reg          stretch_ff;
    reg          read_dir_ff;
    reg          done_en_ff;
    reg          refill_en_ff;
    reg          drain_en_ff;
    reg [15:0]   len_wr_ff;
    reg [15:0]   remain_ff;
    reg [15:0]   limit_ff;
    reg [15:0]   stall_cnt_ff;
    reg          scl_meta_ff;
    reg          scl_sync_ff;
    reg          start_ff;
    reg [31:0]   rdata_ff;

    // Decoded register accesses.
    wire wr_ctrl    = reg_wr && (reg_addr == `ISL_OFF_CTRL);
    wire wr_stat    = reg_wr && (reg_addr == `ISL_OFF_STAT);
    wire wr_len     = reg_wr && (reg_addr == `ISL_OFF_LEN);
    wire wr_data    = reg_wr && (reg_addr == `ISL_OFF_DATA);
    wire wr_stretch = reg_wr && (reg_addr == `ISL_OFF_STRETCH);
    wire rd_data    = reg_rd && (reg_addr == `ISL_OFF_DATA);

    wire clear_req  = wr_ctrl && (reg_wdata[`ISL_C_CLEAR_LO] || reg_wdata[`ISL_C_CLEAR_HI]);
    wire begin_req  = wr_ctrl && reg_wdata[`ISL_C_BEGIN] && !active_ff;

    // Buffer level conditions.
    wire buf_full   = (cnt_ff == CNT_FULL);
    wire buf_empty  = (cnt_ff == {(AW+1){1'b0}});

    // Pushes come from software data writes in any state and from the engine on a read.
    wire push_sw    = wr_data && !buf_full && !clear_req; // RL11
    wire push_eng   = eng_rx_push && !buf_full && active_ff && read_dir_ff;
    wire push       = push_sw || push_eng;
    wire [7:0] push_byte = push_eng ? eng_rx_data : reg_wdata[7:0];
    wire pop_sw     = rd_data && !buf_empty;
    wire pop_eng    = eng_tx_take && !buf_empty && active_ff && !read_dir_ff;
    wire pop        = (pop_sw || pop_eng) && !clear_req;
    wire push_ok    = push && !(push_sw && push_eng);
    wire byte_done  = (eng_tx_take && active_ff && !read_dir_ff) || push_eng;

    // Flags that derive from buffer level and direction.
    wire refill_flag = active_ff && !read_dir_ff && (cnt_ff < CNT_QTR)
                       && ({11'h000, cnt_ff} < remain_ff); // RL4 RL25 RL21
    wire drain_flag  = active_ff && read_dir_ff && (cnt_ff >= CNT_3QTR); // RL7 RL25 RL21

    // A slave stretches when the line stays low although the engine releases it.
    wire stretching = active_ff && scl_release && !scl_sync_ff;
    wire stall_hit  = stretching && scl_tick && (limit_ff != 16'h0000)
                      && (stall_cnt_ff == limit_ff - 16'h0001); // RL23

    // Single buffer storage; write pointer advances on each accepted byte.
    always @(posedge clk) begin
        if (push_ok) begin
            mem_ff[wptr_ff] <= push_byte; // RL21
        end
    end

    // Pointers and fill count; clearing empties the buffer at once.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wptr_ff <= {AW{1'b0}};
            rptr_ff <= {AW{1'b0}};
            cnt_ff  <= {(AW+1){1'b0}};
        end else if (clear_req) begin
            wptr_ff <= {AW{1'b0}};
            rptr_ff <= {AW{1'b0}};
            cnt_ff  <= {(AW+1){1'b0}};
        end else begin
            if (push_ok) begin
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (pop) begin
                rptr_ff <= rptr_ff + 1'b1;
            end
            if (push_ok && !pop) begin
                cnt_ff <= cnt_ff + CNT_ONE;
            end else if (pop && !push_ok) begin
                cnt_ff <= cnt_ff - CNT_ONE;
            end
        end
    end

    // Control fields: direction and interrupt enables.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            read_dir_ff  <= 1'b0;
            done_en_ff   <= 1'b0;
            refill_en_ff <= 1'b0;
            drain_en_ff  <= 1'b0;
        end else if (wr_ctrl) begin
            read_dir_ff  <= reg_wdata[`ISL_C_READ]; // RL24
            done_en_ff   <= reg_wdata[`ISL_C_DONE_EN];
            refill_en_ff <= reg_wdata[`ISL_C_REFILL_EN];
            drain_en_ff  <= reg_wdata[`ISL_C_DRAIN_EN];
        end
    end

    // Begin is a one-cycle pulse toward the engine and never stored as a field.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_ff <= 1'b0;
        end else begin
            start_ff <= begin_req; // RL22
        end
    end

    // Activity tracking: set by begin, ended by the engine's finish pulse.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            active_ff <= 1'b0;
        end else if (begin_req) begin
            active_ff <= 1'b1; // RL1
        end else if (eng_finish) begin
            active_ff <= 1'b0; // RL1
        end
    end

    // Sticky flags; a set in the same cycle as a write-one clear wins.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_ff    <= 1'b0;
            noack_ff   <= 1'b0;
            stretch_ff <= 1'b0;
        end else begin
            if (active_ff && eng_finish) begin
                done_ff <= 1'b1; // RL2
            end else if (begin_req || (wr_stat && reg_wdata[`ISL_S_DONE])) begin
                done_ff <= 1'b0; // RL2
            end
            if (eng_ack_fail) begin
                noack_ff <= 1'b1; // RL15
            end else if (wr_stat && reg_wdata[`ISL_S_NOACK]) begin
                noack_ff <= 1'b0; // RL15
            end
            if (stall_hit) begin
                stretch_ff <= 1'b1; // RL16
            end else if (wr_stat && reg_wdata[`ISL_S_STRETCH]) begin
                stretch_ff <= 1'b0; // RL16
            end
        end
    end

    // Written length is kept across transfers; the live count reloads from it.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            len_wr_ff <= `ISL_RST_LEN;
            remain_ff <= `ISL_RST_LEN;
        end else begin
            if (wr_len) begin
                len_wr_ff <= reg_wdata[15:0]; // RL17 RL20
            end
            if (begin_req) begin
                remain_ff <= wr_len ? reg_wdata[15:0] : len_wr_ff; // RL20
            end else if (byte_done && (remain_ff != 16'h0000)) begin
                remain_ff <= remain_ff - 16'h0001; // RL18
            end
        end
    end

    // Stretch limit register.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            limit_ff <= `ISL_RST_STRETCH;
        end else if (wr_stretch) begin
            limit_ff <= reg_wdata[15:0];
        end
    end

    // Serial clock line passes two flip-flops before any logic sees it.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_meta_ff <= 1'b1;
            scl_sync_ff <= 1'b1;
        end else begin
            scl_meta_ff <= scl_in;
            scl_sync_ff <= scl_meta_ff;
        end
    end

    // Count bit periods while the line is released yet still held low by a slave.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stall_cnt_ff <= 16'h0000;
        end else if (!stretching || stall_hit) begin
            stall_cnt_ff <= 16'h0000;
        end else if (scl_tick && (limit_ff != 16'h0000)) begin
            stall_cnt_ff <= stall_cnt_ff + 16'h0001; // RL23
        end
    end

    // Length read view depends on activity and completion.
    wire [15:0] len_view = active_ff ? remain_ff :
                           done_ff   ? 16'h0000  : len_wr_ff; // RL18 RL19 RL20

    // Status word assembled from live conditions and sticky flags.
    wire [31:0] stat_word = {22'h000000,
                             stretch_ff,
                             noack_ff,
                             buf_full,     // RL9
                             buf_empty,    // RL14
                             !buf_empty,   // RL12
                             !buf_full,    // RL10
                             drain_flag,
                             refill_flag,
                             done_ff,
                             active_ff};

    // Read data is registered; the begin and clear bits read back as zero.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `ISL_OFF_CTRL: begin
                    rdata_ff <= {21'h000000, drain_en_ff, refill_en_ff, done_en_ff,
                                 7'h00, read_dir_ff}; // RL22
                end
                `ISL_OFF_STAT: begin
                    rdata_ff <= stat_word;
                end
                `ISL_OFF_LEN: begin
                    rdata_ff <= {16'h0000, len_view};
                end
                `ISL_OFF_DATA: begin
                    rdata_ff <= {24'h000000, mem_ff[rptr_ff]}; // RL13
                end
                `ISL_OFF_STRETCH: begin
                    rdata_ff <= {16'h0000, limit_ff};
                end
                default: begin
                    rdata_ff <= 32'h00000000;
                end
            endcase
        end
    end

    // Interrupt is a level from flags and their enables.
    assign irq = (done_ff && done_en_ff)        // RL3
              || (refill_flag && refill_en_ff)  // RL5
              || (drain_flag && drain_en_ff);   // RL8

    // Engine handshakes: send only while bytes remain and data is present.
    assign eng_tx_valid = active_ff && !read_dir_ff && !buf_empty
                          && (remain_ff != 16'h0000); // RL6 RL14
    assign eng_rx_room  = !buf_full; // RL9
    assign eng_tx_data  = mem_ff[rptr_ff];
    assign eng_start    = start_ff;
    assign eng_read     = read_dir_ff;
    assign reg_rdata    = rdata_ff;

endmodule

// ---- isl_status_sva.sv ----
// Checker on the register port and engine link of the status block.
// Assumes one clock domain with the asynchronous active-low reset.
`include "isl_defs.vh"
module isl_status_sva (
    input wire        clk,
    input wire        rst_b,
    input wire [7:0]  reg_addr,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire        irq,
    input wire        eng_start,
    input wire        eng_read,
    input wire        eng_tx_valid,
    input wire        eng_finish
);
    reg  [2:0] en_ff;
    wire       st_rd = reg_rd && reg_addr == `ISL_OFF_STAT;
    // Keeps a copy of the three interrupt enables from control writes.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            en_ff <= 3'h0;
        else if (reg_wr && reg_addr == `ISL_OFF_CTRL)
            en_ff <= reg_wdata[10:8];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_start_cause: assert property (
        eng_start |-> $past(reg_wr && reg_addr == `ISL_OFF_CTRL && reg_wdata[7]) ##1 !eng_start)
        else $error("Start pulse without a begin write.");
    chk_txv_dir: assert property (eng_tx_valid |-> !eng_read)
        else $error("Transmit valid during a read.");
    chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("Read data moved without a read.");
    chk_stat_reserved: assert property (
        st_rd |=> reg_rdata[31:10] == 22'h0)
        else $error("Reserved status bits set.");
    chk_ctrl_oneshot: assert property (
        reg_rd && reg_addr == `ISL_OFF_CTRL |=> reg_rdata[7:4] == 4'h0)
        else $error("One-shot control bits read back set.");
    chk_irq_enable: assert property (irq |-> en_ff != 3'h0)
        else $error("Interrupt with all enables off.");
    chk_space_full: assert property (
        st_rd |=> reg_rdata[`ISL_S_SPACE] != reg_rdata[`ISL_S_FULL])
        else $error("Space and full flags agree.");
    chk_data_empty: assert property (
        st_rd |=> reg_rdata[`ISL_S_DATA] != reg_rdata[`ISL_S_EMPTY])
        else $error("Data and empty flags agree.");
    chk_flag_active: assert property (
        st_rd |=> !(reg_rdata[`ISL_S_REFILL] || reg_rdata[`ISL_S_DRAIN]) || reg_rdata[0])
        else $error("Level flag set while idle.");
    chk_finish_idle: assert property (eng_finish |=> !eng_tx_valid)
        else $error("Transmit valid after finish.");
endmodule
bind isl_status isl_status_sva u_sva (.*);

// ---- isl_eng_model.sv ----
// Behavioural byte engine with a stretching slave on the serial clock line.
// Assumes the bench supplies the byte count and the stretch request.
module isl_eng_model (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        eng_start,
    input  wire        eng_read,
    input  wire        eng_tx_valid,
    input  wire [7:0]  eng_tx_data,
    input  wire        eng_rx_room,
    input  wire [15:0] xfer_len,
    input  wire        stretch,
    output reg         eng_tx_take,
    output reg         eng_rx_push,
    output reg  [7:0]  eng_rx_data,
    output reg         eng_finish,
    output wire        scl_in,
    output wire        scl_release,
    output reg         scl_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    reg        free_scl;
    reg        busy_ff;
    reg [15:0] cnt_ff;
    reg [1:0]  gap_ff;
    reg [1:0]  sync_ff;
    reg [7:0]  last_tx;
    wire       step = busy_ff && gap_ff == 2'h3;
    // Serial clock runs free but reaches the pulled-up line only inside a frame.
    initial begin
        free_scl = 1'b0;
        forever #200 free_scl = ~free_scl;
    end
    assign scl_in      = !busy_ff || (!stretch && free_scl);
    assign scl_release = busy_ff && (stretch || sync_ff[1]);
    // Moves one byte every four cycles and finishes once the count is reached.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {busy_ff, cnt_ff, gap_ff, sync_ff, last_tx} <= 29'h0;
            {eng_tx_take, eng_rx_push, eng_finish, scl_tick} <= 4'h0;
            eng_rx_data <= 8'h00;
        end else begin
            sync_ff     <= {sync_ff[0], free_scl};
            scl_tick    <= sync_ff == 2'h1;
            gap_ff      <= gap_ff + 2'h1;
            eng_tx_take <= 1'b0;
            eng_rx_push <= 1'b0;
            eng_finish  <= 1'b0;
            if (eng_start) begin
                busy_ff <= 1'b1;
                cnt_ff  <= 16'h0;
            end else if (step && cnt_ff == xfer_len) begin
                busy_ff    <= 1'b0;
                eng_finish <= 1'b1;
            end else if (step && !eng_read && eng_tx_valid) begin
                eng_tx_take <= 1'b1;
                last_tx     <= eng_tx_data;
                cnt_ff      <= cnt_ff + 16'h1;
            end else if (step && eng_read && eng_rx_room) begin
                eng_rx_push <= 1'b1;
                eng_rx_data <= 8'ha0 + cnt_ff[7:0];
                cnt_ff      <= cnt_ff + 16'h1;
            end
        end
    end
endmodule

// ---- tb.sv ----
// Self-checking bench of the status block against a behavioural byte engine.
// Assumes a 20 MHz core clock and a 400 ns serial clock from the model.
`include "isl_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    reg         clk = 1'b0;
    reg         rst_b = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg  [31:0] reg_wdata = 32'h0;
    reg         eng_ack_fail = 1'b0;
    reg         stretch = 1'b0;
    reg  [15:0] xfer_len = 16'h0;
    reg  [31:0] rv;
    wire [31:0] reg_rdata;
    wire [7:0]  eng_tx_data, eng_rx_data;
    wire        irq, eng_start, eng_read, eng_tx_valid, eng_tx_take, eng_rx_push;
    wire        eng_rx_room, eng_finish, scl_in, scl_release, scl_tick;
    integer     fail_count = 0;
    integer     total_checks = 0;
    integer     i;
    isl_status u_dut (.*);
    isl_eng_model u_eng (.*);
    // Core clock.
    initial forever #25 clk = ~clk;
    // Register access, comparison and ending tasks.
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            reg_addr  <= a;
            reg_wdata <= d;
            reg_wr    <= 1'b1;
            @(posedge clk);
            reg_wr    <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_rd   <= 1'b1;
            @(posedge clk);
            reg_rd   <= 1'b0;
            @(posedge clk);
            #1 rv = reg_rdata;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task rdc(input [7:0] a, input [31:0] exp);
        begin
            rd(a);
            chk(rv, exp);
        end
    endtask
    task wrap_up;
        begin
            $display("Checks %0d, mismatches %0d", total_checks, fail_count);
            if (fail_count == 0 && total_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task wait_stat(input integer b);
        integer n;
        begin
            n = 0;
            rd(`ISL_OFF_STAT);
            while (rv[b] !== 1'b1 && n < 400) begin
                rd(`ISL_OFF_STAT);
                n = n + 1;
            end
            if (rv[b] !== 1'b1) begin
                fail_count = fail_count + 1;
                $display("Error at %0t ns: status wait ran out", $time);
                wrap_up;
            end
        end
    endtask
    // Main sequence.
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rdc(`ISL_OFF_STAT, 32'h0000_0050);
        rdc(`ISL_OFF_LEN, `ISL_RST_LEN);
        rdc(`ISL_OFF_STRETCH, `ISL_RST_STRETCH);
        rdc(8'h0c, 32'h0);
        rdc(`ISL_OFF_CTRL, 32'h0);
        $display("Test reset values ended");
        xfer_len <= 16'h3;
        wr(`ISL_OFF_LEN, 32'h3);
        rdc(`ISL_OFF_LEN, 32'h3);
        wr(`ISL_OFF_CTRL, 32'h0000_0380);
        rdc(`ISL_OFF_STAT, 32'h0000_0055);
        chk(irq, 32'h1);
        repeat (40) @(posedge clk);
        rdc(`ISL_OFF_LEN, 32'h3);
        for (i = 0; i < 3; i++) wr(`ISL_OFF_DATA, 32'h10 + i);
        wait_stat(`ISL_S_DONE);
        chk(u_eng.last_tx, 32'h12);
        rdc(`ISL_OFF_STAT, 32'h0000_0052);
        rdc(`ISL_OFF_LEN, 32'h0);
        chk(irq, 32'h1);
        wr(`ISL_OFF_STAT, 32'h0);
        rdc(`ISL_OFF_STAT, 32'h0000_0052);
        wr(`ISL_OFF_STAT, 32'h2);
        rdc(`ISL_OFF_STAT, 32'h0000_0050);
        chk(irq, 32'h0);
        rdc(`ISL_OFF_LEN, 32'h3);
        $display("Test write transfer ended");
        for (i = 0; i < 17; i++) wr(`ISL_OFF_DATA, i);
        rdc(`ISL_OFF_STAT, 32'h0000_00a0);
        xfer_len <= 16'h10;
        wr(`ISL_OFF_LEN, 32'h10);
        wr(`ISL_OFF_CTRL, 32'h0000_0080);
        wait_stat(`ISL_S_DONE);
        chk(u_eng.last_tx, 32'h0f);
        wr(`ISL_OFF_STAT, 32'h2);
        $display("Test full buffer ended");
        xfer_len <= 16'h14;
        wr(`ISL_OFF_LEN, 32'h14);
        wr(`ISL_OFF_CTRL, 32'h0000_0481);
        repeat (100) @(posedge clk);
        rdc(`ISL_OFF_STAT, 32'h0000_00a9);
        chk(irq, 32'h1);
        rdc(`ISL_OFF_LEN, 32'h4);
        for (i = 0; i < 20; i++) begin
            wait_stat(`ISL_S_DATA);
            rdc(`ISL_OFF_DATA, 32'ha0 + i);
        end
        wait_stat(`ISL_S_DONE);
        rdc(`ISL_OFF_STAT, 32'h0000_0052);
        chk(irq, 32'h0);
        wr(`ISL_OFF_STAT, 32'h2);
        $display("Test read transfer ended");
        xfer_len <= 16'h1;
        wr(`ISL_OFF_LEN, 32'h1);
        wr(`ISL_OFF_STRETCH, 32'h3);
        wr(`ISL_OFF_CTRL, 32'h0000_0080);
        @(posedge clk) eng_ack_fail <= 1'b1;
        @(posedge clk) eng_ack_fail <= 1'b0;
        rdc(`ISL_OFF_STAT, 32'h0000_0155);
        stretch <= 1'b1;
        repeat (70) @(posedge clk);
        stretch <= 1'b0;
        rdc(`ISL_OFF_STAT, 32'h0000_0355);
        wr(`ISL_OFF_STAT, 32'h0);
        rdc(`ISL_OFF_STAT, 32'h0000_0355);
        wr(`ISL_OFF_STAT, 32'h300);
        rdc(`ISL_OFF_STAT, 32'h0000_0055);
        wr(`ISL_OFF_STRETCH, 32'h0);
        stretch <= 1'b1;
        repeat (70) @(posedge clk);
        stretch <= 1'b0;
        rdc(`ISL_OFF_STAT, 32'h0000_0055);
        wr(`ISL_OFF_DATA, 32'h5a);
        wait_stat(`ISL_S_DONE);
        chk(u_eng.last_tx, 32'h5a);
        $display("Test error flags ended");
        wrap_up;
    end
endmodule
